// ### fbx_cond.sv
// Branch condition evaluator for the execution block.
// Assumes the opcode and flags are stable register outputs on the same clock.
`timescale 1ns/10ps
module fbx_cond (
	input  wire logic [5:0] op,
	input  wire logic [7:0] flags,
	output logic            is_branch,
	output logic            take
);

	logic c;
	logic n;
	logic v;
	logic h;
	logic t;
	logic i;

	// Flag taps
	assign c = flags[fbx_pkg::FLAG_C];
	assign n = flags[fbx_pkg::FLAG_N];
	assign v = flags[fbx_pkg::FLAG_V];
	assign h = flags[fbx_pkg::FLAG_H];
	assign t = flags[fbx_pkg::FLAG_T];
	assign i = flags[fbx_pkg::FLAG_I];

	// One condition per branch opcode; anything else never branches
	always_comb begin
		is_branch = 1'b1;
		take      = 1'b0;
		case (fbx_pkg::fbx_op_t'(op))
			fbx_pkg::OP_BRANCH_ON_CARRY_ZERO:  take = ~c;      // see RL1
			fbx_pkg::OP_BRANCH_SAME_OR_HIGHER: take = ~c;      // see RL1
			fbx_pkg::OP_BRANCH_UNSIGNED_LOWER: take = c;       // see RL1
			fbx_pkg::OP_BRANCH_NEGATIVE:       take = n;       // see RL2
			fbx_pkg::OP_BRANCH_POSITIVE:       take = ~n;      // see RL2
			fbx_pkg::OP_BRANCH_SIGNED_GE:      take = ~(n ^ v); // see RL3
			fbx_pkg::OP_BRANCH_SIGNED_LT:      take = n ^ v;   // see RL3
			fbx_pkg::OP_BRANCH_HALFCARRY_ONE:  take = h;       // see RL4
			fbx_pkg::OP_BRANCH_HALFCARRY_ZERO: take = ~h;      // see RL4
			fbx_pkg::OP_BRANCH_TRANSFER_ONE:   take = t;       // see RL5
			fbx_pkg::OP_BRANCH_TRANSFER_ZERO:  take = ~t;      // see RL5
			fbx_pkg::OP_BRANCH_OVERFLOW_ONE:   take = v;       // see RL6
			fbx_pkg::OP_BRANCH_OVERFLOW_ZERO:  take = ~v;      // see RL6
			fbx_pkg::OP_BRANCH_IRQ_ENABLED:    take = i;       // see RL7
			fbx_pkg::OP_BRANCH_IRQ_DISABLED:   take = ~i;      // see RL7
			default: begin
				is_branch = 1'b0;
			end
		endcase
	end

endmodule

// ### fbx_exec.sv
// Execution core for flag branches, I/O bit forcing, shifts and flag moves.
// Assumes an APB master on pclk; one instruction runs per write to the instruction register.
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/10ps

// Notes on behaviour
// RL1 - Carry branches jump PC+k+1 on carry clear or set; one or two cycles.
// RL2 - Negative and positive branches test the negative flag; one or two cycles.
// RL3 - Signed ge and lt branches test negative xor overflow; one or two cycles.
// RL4 - Half-carry branches jump when half carry is one or zero.
// RL5 - Transfer flag branches jump when T is one or zero.
// RL6 - Overflow branches jump when the overflow flag is one or zero.
// RL7 - Interrupt-state branches jump when the global interrupt flag is one or zero.
// RL8 - I/O bit force sets or clears one I/O bit, flags untouched, two cycles.
// RL9 - Logical left shift fills bit zero with zero, updates Z C N V, one cycle.
// RL10 - Logical right shift fills bit seven with zero, updates Z C N V, one cycle.
// RL11 - Rotate left takes old carry into bit zero, bit seven to carry.
// RL12 - Rotate right takes old carry into bit seven, bit zero to carry.
// RL13 - Arithmetic right shift keeps bit seven, updates Z C N V.
// RL14 - Flag force instructions write exactly one status bit, one cycle.
// RL15 - Bit store copies a working register bit into T, one cycle.
// RL16 - Bit load copies T into one working register bit, one cycle.
// RL17 - Overflow force zero clears V, its counterpart sets V, one cycle.
// RL18 - Branch offset is signed; only a true condition takes two cycles.
// RL19 - Arithmetic right shift completes in one cycle.
module fbx_exec #(
	parameter int IO_DEPTH = 32
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             exec_busy,
	output logic [15:0]      prog_counter
);

	// The I/O window holds at most 32 words in the upper half of the map
	generate
		if (IO_DEPTH < 1 || IO_DEPTH > 32) begin : g_bad_depth
			$error("IO_DEPTH must lie between 1 and 32");
		end
	endgenerate

	typedef struct packed {
		fbx_pkg::fbx_state_t          fsm;
		logic [31:0]                  insn;
		logic [15:0]                  pc;
		logic [7:0]                   flags;
		logic [7:0]                   work;
		logic [IO_DEPTH-1:0][7:0]     io;
		logic [1:0]                   last_cyc;
		logic                         taken;
		logic [15:0]                  retired;
		logic                         busy;
		logic                         pready;
		logic                         pslverr;
		logic [31:0]                  prdata;
	} fbx_regs_t;

	fbx_regs_t   s_q;
	fbx_regs_t   s_d;

	logic [5:0]  op;
	logic [2:0]  bit_sel;
	logic [4:0]  io_sel;
	logic [7:0]  offset;
	logic [15:0] offset_ext;
	logic        is_branch;
	logic        take;
	logic [7:0]  sh_result;
	logic        sh_c;
	logic        sh_z;
	logic        sh_n;
	logic        sh_v;
	logic        is_shift;
	fbx_pkg::fbx_hit_t hit;

	// Map a byte address to a register; unmapped I/O words fall to none
	function automatic fbx_pkg::fbx_hit_t decode(input logic [7:0] addr);
		fbx_pkg::fbx_hit_t r;
		r = fbx_pkg::HIT_NONE;
		if (addr[1:0] != 2'h0) begin
			r = fbx_pkg::HIT_NONE;
		end else if (addr >= fbx_pkg::ADDR_IO_BASE) begin
			if (32'(addr[6:2]) < IO_DEPTH) begin
				r = fbx_pkg::HIT_IO;
			end
		end else begin
			case (addr)
				fbx_pkg::ADDR_INSN:    r = fbx_pkg::HIT_INSN;
				fbx_pkg::ADDR_PC:      r = fbx_pkg::HIT_PC;
				fbx_pkg::ADDR_FLAGS:   r = fbx_pkg::HIT_FLAGS;
				fbx_pkg::ADDR_WORK:    r = fbx_pkg::HIT_WORK;
				fbx_pkg::ADDR_STAT:    r = fbx_pkg::HIT_STAT;
				fbx_pkg::ADDR_RETIRED: r = fbx_pkg::HIT_RETIRED;
				default:               r = fbx_pkg::HIT_NONE;
			endcase
		end
		return r;
	endfunction

	// Read mux; narrow registers sit in the low bits with zeros above
	function automatic logic [31:0] read_word(input fbx_regs_t st, input fbx_pkg::fbx_hit_t h,
		input logic [4:0] idx);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (h)
			fbx_pkg::HIT_INSN:    r = st.insn;
			fbx_pkg::HIT_PC:      r = {16'h0000, st.pc};
			fbx_pkg::HIT_FLAGS:   r = {24'h00_0000, st.flags};
			fbx_pkg::HIT_WORK:    r = {24'h00_0000, st.work};
			fbx_pkg::HIT_RETIRED: r = {16'h0000, st.retired};
			fbx_pkg::HIT_IO:      r = {24'h00_0000, st.io[idx]};
			fbx_pkg::HIT_STAT: begin
				r[fbx_pkg::STAT_BUSY]                    = (st.fsm != fbx_pkg::ST_IDLE);
				r[fbx_pkg::STAT_CYC +: 2]                = st.last_cyc;
				r[fbx_pkg::STAT_TAKEN]                   = st.taken;
			end
			default:              r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	// Instruction fields
	assign op         = s_q.insn[fbx_pkg::INSN_OP_LSB +: 6];
	assign bit_sel    = s_q.insn[fbx_pkg::INSN_BIT_LSB +: 3];
	assign io_sel     = s_q.insn[fbx_pkg::INSN_IO_LSB +: 5];
	assign offset     = s_q.insn[fbx_pkg::INSN_OFS_LSB +: 8];
	assign offset_ext = {{8{offset[7]}}, offset}; // see RL18
	assign hit        = decode(paddr);
	assign is_shift   = (op >= fbx_pkg::OP_SHIFT_LEFT_LOGICAL) && (op <= fbx_pkg::OP_SHIFT_RIGHT_ARITH);

	fbx_cond u_cond (
		.op        (op),
		.flags     (s_q.flags),
		.is_branch (is_branch),
		.take      (take)
	);

	fbx_shift u_shift (
		.op       (op),
		.value    (s_q.work),
		.carry_in (s_q.flags[fbx_pkg::FLAG_C]),
		.result   (sh_result),
		.flag_c   (sh_c),
		.flag_z   (sh_z),
		.flag_n   (sh_n),
		.flag_v   (sh_v)
	);

	// Next state: bus slave first, then the execution sequencer
	always_comb begin
		s_d = s_q;

		// APB: one wait state; the slave stalls while an instruction runs so that
		// software never sees a half-updated flag or register set
		if (s_q.pready) begin
			s_d.pready  = 1'b0;
			s_d.pslverr = 1'b0;
			if (pwrite && !s_q.pslverr) begin
				case (hit)
					fbx_pkg::HIT_INSN: begin
						s_d.insn = pwdata;
						s_d.fsm  = fbx_pkg::ST_EXEC;
					end
					fbx_pkg::HIT_PC:    s_d.pc    = pwdata[15:0];
					fbx_pkg::HIT_FLAGS: s_d.flags = pwdata[7:0];
					fbx_pkg::HIT_WORK:  s_d.work  = pwdata[7:0];
					fbx_pkg::HIT_IO:    s_d.io[paddr[6:2]] = pwdata[7:0];
					default: begin
						s_d.pready = 1'b0;
					end
				endcase
			end
		end else if (psel && penable && s_q.fsm == fbx_pkg::ST_IDLE) begin
			s_d.pready  = 1'b1;
			s_d.pslverr = (hit == fbx_pkg::HIT_NONE) ||
				(pwrite && (hit == fbx_pkg::HIT_STAT || hit == fbx_pkg::HIT_RETIRED));
			s_d.prdata  = pwrite ? 32'h0000_0000 : read_word(s_q, hit, paddr[6:2]);
		end

		// Sequencer
		case (s_q.fsm)
			fbx_pkg::ST_EXEC: begin
				s_d.fsm      = fbx_pkg::ST_IDLE;
				s_d.pc       = s_q.pc + 16'h0001;
				s_d.last_cyc = fbx_pkg::CYC_ONE;
				s_d.taken    = 1'b0;
				s_d.retired  = s_q.retired + 16'h0001;
				if (is_branch) begin
					// Only a true condition pays the second cycle
					if (take) begin
						s_d.pc       = s_q.pc + offset_ext + 16'h0001; // see RL1 RL2 RL3 RL4 RL5 RL6 RL7
						s_d.fsm      = fbx_pkg::ST_HOLD;               // see RL18
						s_d.last_cyc = fbx_pkg::CYC_TWO;
						s_d.taken    = 1'b1;
					end
				end else if (is_shift) begin
					// Shifts write back in the same cycle; S stays as it was
					s_d.work                   = sh_result;        // see RL9 RL10 RL11 RL12 RL13 RL19
					s_d.flags[fbx_pkg::FLAG_C] = sh_c;
					s_d.flags[fbx_pkg::FLAG_Z] = sh_z;
					s_d.flags[fbx_pkg::FLAG_N] = sh_n;
					s_d.flags[fbx_pkg::FLAG_V] = sh_v;
				end else begin
					case (fbx_pkg::fbx_op_t'(op))
						fbx_pkg::OP_IO_BIT_FORCE_ONE, fbx_pkg::OP_IO_BIT_FORCE_ZERO: begin
							// Out-of-range I/O words are left alone but still cost two cycles
							if (32'(io_sel) < IO_DEPTH) begin
								s_d.io[io_sel][bit_sel] = (op == fbx_pkg::OP_IO_BIT_FORCE_ONE); // see RL8
							end
							s_d.fsm      = fbx_pkg::ST_HOLD;              // see RL8
							s_d.last_cyc = fbx_pkg::CYC_TWO;
						end
						fbx_pkg::OP_STATUS_BIT_FORCE_ONE:  s_d.flags[bit_sel] = 1'b1;          // see RL14
						fbx_pkg::OP_STATUS_BIT_FORCE_ZERO: s_d.flags[bit_sel] = 1'b0;          // see RL14
						fbx_pkg::OP_COPY_BIT_TO_TRANSFER_FLAG: begin
							s_d.flags[fbx_pkg::FLAG_T] = s_q.work[bit_sel];                   // see RL15
						end
						fbx_pkg::OP_COPY_TRANSFER_FLAG_TO_BIT: begin
							s_d.work[bit_sel] = s_q.flags[fbx_pkg::FLAG_T];                   // see RL16
						end
						fbx_pkg::OP_OVERFLOW_FLAG_FORCE_ONE:   s_d.flags[fbx_pkg::FLAG_V] = 1'b1; // see RL17
						fbx_pkg::OP_OVERFLOW_FLAG_FORCE_ZERO:  s_d.flags[fbx_pkg::FLAG_V] = 1'b0; // see RL17
						fbx_pkg::OP_HALFCARRY_FLAG_FORCE_ONE:  s_d.flags[fbx_pkg::FLAG_H] = 1'b1; // see RL14
						fbx_pkg::OP_HALFCARRY_FLAG_FORCE_ZERO: s_d.flags[fbx_pkg::FLAG_H] = 1'b0; // see RL14
						default: begin
							s_d.flags = s_q.flags; // Unknown codes act as a one-cycle no-op
						end
					endcase
				end
			end
			fbx_pkg::ST_HOLD: begin
				s_d.fsm = fbx_pkg::ST_IDLE; // Second cycle of a two-cycle instruction
			end
			default: begin
				s_d.fsm = s_d.fsm;
			end
		endcase

		// Busy is kept as its own flop so the port has no decode behind it
		s_d.busy = (s_d.fsm != fbx_pkg::ST_IDLE);
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q          <= '0;
			s_q.fsm      <= fbx_pkg::ST_IDLE;
			s_q.pc       <= fbx_pkg::PC_RST;
			s_q.flags    <= fbx_pkg::FLAGS_RST;
			s_q.work     <= fbx_pkg::WORK_RST;
			s_q.last_cyc <= 2'h0;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state register
	assign prdata       = s_q.prdata;
	assign pready       = s_q.pready;
	assign pslverr      = s_q.pslverr;
	assign exec_busy    = s_q.busy;
	assign prog_counter = s_q.pc;

endmodule

// ### fbx_exec_assertions.sv
// Port-level assertions for the flag, branch, bit and shift execution block.
// Assumes it is bound to fbx_exec and that the APB master holds each request until pready.
`timescale 1ns/10ps
module fbx_chk #(
	parameter int IO_DEPTH = 32
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        exec_busy,
	input wire logic [15:0] prog_counter
);
	logic        ins_wr;
	logic        pc_wr;
	logic [5:0]  op_q;
	logic [15:0] base_q;
	logic [7:0]  ofs_q;
	logic [1:0]  blen_q;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Accepted writes to the instruction and counter registers
	assign ins_wr = psel && penable && pready && pwrite && !pslverr && paddr == fbx_pkg::ADDR_INSN;
	assign pc_wr  = psel && penable && pready && pwrite && !pslverr && paddr == fbx_pkg::ADDR_PC;

	// Keep the issued op and start PC; busy cycles are counted so the retire checks see the cost
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_q   <= 6'h00;
			base_q <= 16'h0000;
			ofs_q  <= 8'h00;
			blen_q <= 2'h0;
		end else begin
			if (ins_wr) begin
				op_q   <= pwdata[5:0];
				base_q <= prog_counter;
				ofs_q  <= pwdata[31:24];
			end
			blen_q <= exec_busy ? blen_q + 2'h1 : 2'h0;
		end
	end

	ready_needs_access_a: assert property (pready |-> psel && penable)
		else $error("pready without an access phase");
	ready_bounded_a: assert property ($rose(penable) |-> ##[1:4] pready)
		else $error("pready late");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	write_rdata_zero_a: assert property (pready && pwrite |-> prdata == 32'h0)
		else $error("prdata not zero on a write");
	insn_starts_a: assert property (ins_wr |=> exec_busy)
		else $error("instruction write did not start execution");
	busy_max_two_a: assert property (exec_busy ##1 exec_busy |=> !exec_busy)
		else $error("execution longer than two cycles");
	branch_target_a: assert property ($fell(exec_busy) && op_q >= 6'h01 && op_q <= 6'h0f
		|-> (blen_q == 2'h1 && prog_counter == base_q + 16'h0001)
		|| (blen_q == 2'h2 && prog_counter == base_q + {{8{ofs_q[7]}}, ofs_q} + 16'h0001))
		else $error("branch target or cost wrong");
	single_cycle_op_a: assert property ($fell(exec_busy) && ((op_q >= 6'h18 && op_q <= 6'h1c)
		|| (op_q >= 6'h20 && op_q <= 6'h27)) |-> blen_q == 2'h1 && prog_counter == base_q + 16'h0001)
		else $error("shift or flag op not one cycle");
	io_force_cost_a: assert property ($fell(exec_busy) && op_q[5:1] == 5'h08
		|-> blen_q == 2'h2 && prog_counter == base_q + 16'h0001)
		else $error("io bit force not two cycles");
	pc_change_cause_a: assert property ($changed(prog_counter) |-> $past(exec_busy) || $past(pc_wr))
		else $error("program counter moved without cause");
endmodule

// ### fbx_pkg.sv
// Shared constants for the flag, branch, bit and shift execution block.
// Assumes a 32-bit APB register port with byte addresses in the low eight bits.
package fbx_pkg;

	// Register byte offsets
	localparam logic [7:0] ADDR_INSN    = 8'h00;
	localparam logic [7:0] ADDR_PC      = 8'h04;
	localparam logic [7:0] ADDR_FLAGS   = 8'h08;
	localparam logic [7:0] ADDR_WORK    = 8'h0c;
	localparam logic [7:0] ADDR_STAT    = 8'h10;
	localparam logic [7:0] ADDR_RETIRED = 8'h14;
	localparam logic [7:0] ADDR_IO_BASE = 8'h80;

	// Instruction word fields
	localparam int INSN_OP_LSB  = 0;
	localparam int INSN_BIT_LSB = 8;
	localparam int INSN_IO_LSB  = 16;
	localparam int INSN_OFS_LSB = 24;

	// Status flag positions inside status_flags_register
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;

	// Status register fields
	localparam int STAT_BUSY  = 0;
	localparam int STAT_CYC   = 4;
	localparam int STAT_TAKEN = 8;

	// Reset values and cycle costs
	localparam logic [15:0] PC_RST    = 16'h0000;
	localparam logic [7:0]  FLAGS_RST = 8'h00;
	localparam logic [7:0]  WORK_RST  = 8'h00;
	localparam logic [1:0]  CYC_ONE   = 2'h1;
	localparam logic [1:0]  CYC_TWO   = 2'h2;

	// Opcodes written into the low six bits of the instruction register
	typedef enum logic [5:0] {
		OP_NOP                       = 6'h00,
		OP_BRANCH_ON_CARRY_ZERO      = 6'h01,
		OP_BRANCH_SAME_OR_HIGHER     = 6'h02,
		OP_BRANCH_UNSIGNED_LOWER     = 6'h03,
		OP_BRANCH_NEGATIVE           = 6'h04,
		OP_BRANCH_POSITIVE           = 6'h05,
		OP_BRANCH_SIGNED_GE          = 6'h06,
		OP_BRANCH_SIGNED_LT          = 6'h07,
		OP_BRANCH_HALFCARRY_ONE      = 6'h08,
		OP_BRANCH_HALFCARRY_ZERO     = 6'h09,
		OP_BRANCH_TRANSFER_ONE       = 6'h0a,
		OP_BRANCH_TRANSFER_ZERO      = 6'h0b,
		OP_BRANCH_OVERFLOW_ONE       = 6'h0c,
		OP_BRANCH_OVERFLOW_ZERO      = 6'h0d,
		OP_BRANCH_IRQ_ENABLED        = 6'h0e,
		OP_BRANCH_IRQ_DISABLED       = 6'h0f,
		OP_IO_BIT_FORCE_ONE          = 6'h10,
		OP_IO_BIT_FORCE_ZERO         = 6'h11,
		OP_SHIFT_LEFT_LOGICAL        = 6'h18,
		OP_SHIFT_RIGHT_LOGICAL       = 6'h19,
		OP_ROTATE_LEFT_CARRY         = 6'h1a,
		OP_ROTATE_RIGHT_CARRY        = 6'h1b,
		OP_SHIFT_RIGHT_ARITH         = 6'h1c,
		OP_STATUS_BIT_FORCE_ONE      = 6'h20,
		OP_STATUS_BIT_FORCE_ZERO     = 6'h21,
		OP_COPY_BIT_TO_TRANSFER_FLAG = 6'h22,
		OP_COPY_TRANSFER_FLAG_TO_BIT = 6'h23,
		OP_OVERFLOW_FLAG_FORCE_ONE   = 6'h24,
		OP_OVERFLOW_FLAG_FORCE_ZERO  = 6'h25,
		OP_HALFCARRY_FLAG_FORCE_ONE  = 6'h26,
		OP_HALFCARRY_FLAG_FORCE_ZERO = 6'h27
	} fbx_op_t;

	// Register decode targets
	typedef enum logic [2:0] {
		HIT_NONE,
		HIT_INSN,
		HIT_PC,
		HIT_FLAGS,
		HIT_WORK,
		HIT_STAT,
		HIT_RETIRED,
		HIT_IO
	} fbx_hit_t;

	// Execution sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_EXEC,
		ST_HOLD
	} fbx_state_t;

endpackage

// ### fbx_shift.sv
// Single-register shift and rotate unit with its flag results.
// Assumes operand and carry come from registers on the same clock.
`timescale 1ns/10ps
module fbx_shift (
	input  wire logic [5:0] op,
	input  wire logic [7:0] value,
	input  wire logic       carry_in,
	output logic [7:0]      result,
	output logic            flag_c,
	output logic            flag_z,
	output logic            flag_n,
	output logic            flag_v
);

	// Data path and carry out per operation
	always_comb begin
		result = value;
		flag_c = carry_in;
		case (fbx_pkg::fbx_op_t'(op))
			fbx_pkg::OP_SHIFT_LEFT_LOGICAL: begin
				result = {value[6:0], 1'b0};     // see RL9
				flag_c = value[7];
			end
			fbx_pkg::OP_SHIFT_RIGHT_LOGICAL: begin
				result = {1'b0, value[7:1]};     // see RL10
				flag_c = value[0];
			end
			fbx_pkg::OP_ROTATE_LEFT_CARRY: begin
				result = {value[6:0], carry_in}; // see RL11
				flag_c = value[7];
			end
			fbx_pkg::OP_ROTATE_RIGHT_CARRY: begin
				result = {carry_in, value[7:1]}; // see RL12
				flag_c = value[0];
			end
			fbx_pkg::OP_SHIFT_RIGHT_ARITH: begin
				result = {value[7], value[7:1]}; // see RL13
				flag_c = value[0];
			end
			default: begin
				result = value;
			end
		endcase
	end

	// Result flags; overflow is sign xor carry after the move
	assign flag_n = result[7];
	assign flag_z = (result == 8'h00);
	assign flag_v = result[7] ^ flag_c;

endmodule

// ### tb_top.sv
// Self-checking bench for the execution block, driving APB directly.
// Assumes fbx_pkg and fbx_exec are compiled first; the checker is bound below.
`timescale 1ns/10ps
module tb_top;
	localparam int          IO_N = 8;
	localparam logic [31:0] FLS  = 32'h0804ff00;
	localparam logic [23:0] WS   = 24'h014081;
	localparam logic [7:0]  BSRC = 8'ha5;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        exec_busy;
	logic [15:0] prog_counter;
	logic [31:0] rdat;
	logic        rerr;
	int          error_cnt;
	int          checked;
	int          ninsn;

	fbx_exec #(.IO_DEPTH(IO_N)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .exec_busy(exec_busy), .prog_counter(prog_counter));

	// Core clock, 8 ns period
	always #4 pclk = ~pclk;

	task end_of_test;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One APB transfer; an idle cycle between transfers keeps each signal to one update per edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			error_cnt++;
			$display("[FAIL] pready expected 1 seen %b", pready);
			end_of_test();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic ex(input logic [5:0] op, input logic [2:0] b, input logic [4:0] io, input logic [7:0] k);
		wr(fbx_pkg::ADDR_INSN, {k, 3'h0, io, 5'h00, b, 2'h0, op});
		ninsn++;
	endtask

	// Expected branch decision from the opcode and flag byte
	function automatic logic bcond(input logic [5:0] op, input logic [7:0] f);
		case (op)
			6'h01, 6'h02: return !f[0];
			6'h03: return f[0];
			6'h04: return f[2];
			6'h05: return !f[2];
			6'h06: return !(f[2] ^ f[3]);
			6'h07: return f[2] ^ f[3];
			6'h08: return f[5];
			6'h09: return !f[5];
			6'h0a: return f[6];
			6'h0b: return !f[6];
			6'h0c: return f[3];
			6'h0d: return !f[3];
			6'h0e: return f[7];
			default: return !f[7];
		endcase
	endfunction

	task automatic t_reset;
		chk("pc port", 32'h0, {16'h0, prog_counter});
		rd(fbx_pkg::ADDR_FLAGS);
		chk("flags reset", 32'h0, rdat);
		rd(fbx_pkg::ADDR_WORK);
		chk("work reset", 32'h0, rdat);
		rd(8'h40);
		chk("unmapped err", 32'h1, {31'h0, rerr});
		rd(8'h06);
		chk("misaligned err", 32'h1, {31'h0, rerr});
		wr(fbx_pkg::ADDR_STAT, 32'h1);
		chk("stat write err", 32'h1, {31'h0, rerr});
		$display("test reset done");
	endtask

	// Every branch form against four flag patterns, with extreme offsets both ways
	task automatic t_branch;
		logic [7:0]  f;
		logic [7:0]  k;
		logic        tk;
		logic [15:0] pc;
		for (int i = 0; i < 4; i++) begin
			for (int op = 1; op < 16; op++) begin
				f = FLS[i*8 +: 8];
				k = f[0] ? 8'h80 : 8'h7f;
				tk = bcond(op[5:0], f);
				pc = tk ? 16'h0101 + {{8{k[7]}}, k} : 16'h0101;
				wr(fbx_pkg::ADDR_PC, 32'h0100);
				wr(fbx_pkg::ADDR_FLAGS, {24'h0, f});
				ex(op[5:0], 3'h0, 5'h00, k);
				rd(fbx_pkg::ADDR_PC);
				chk("branch pc", {16'h0, pc}, rdat);
				rd(fbx_pkg::ADDR_STAT);
				chk("branch stat", {23'h0, tk, 2'h0, tk ? 2'h2 : 2'h1, 4'h0}, rdat & 32'h131);
			end
		end
		$display("test branch done");
	endtask

	task automatic t_shift;
		logic [7:0] w;
		logic [7:0] r;
		logic       c;
		logic       ci;
		for (int op = 6'h18; op <= 6'h1c; op++) begin
			for (int j = 0; j < 6; j++) begin
				w = WS[(j % 3)*8 +: 8];
				ci = (j >= 3);
				case (op)
					6'h18: {c, r} = {w, 1'b0};
					6'h19: {r, c} = {1'b0, w};
					6'h1a: {c, r} = {w, ci};
					6'h1b: {r, c} = {ci, w};
					default: {r, c} = {w[7], w};
				endcase
				wr(fbx_pkg::ADDR_WORK, {24'h0, w});
				wr(fbx_pkg::ADDR_FLAGS, {24'h0, 4'h5, 3'h0, ci});
				ex(op[5:0], 3'h0, 5'h00, 8'h00);
				rd(fbx_pkg::ADDR_WORK);
				chk("shift result", {24'h0, r}, rdat);
				rd(fbx_pkg::ADDR_FLAGS);
				chk("shift flags", {24'h0, 4'h5, r[7] ^ c, r[7], r == 8'h00, c}, rdat);
			end
		end
		rd(fbx_pkg::ADDR_STAT);
		chk("shift cycles", 32'h10, rdat & 32'h30);
		$display("test shift done");
	endtask

	task automatic t_flag;
		for (int s = 0; s < 8; s++) begin
			wr(fbx_pkg::ADDR_FLAGS, 32'h00);
			ex(6'h20, s[2:0], 5'h00, 8'h00);
			rd(fbx_pkg::ADDR_FLAGS);
			chk("flag force one", 32'h1 << s, rdat);
			wr(fbx_pkg::ADDR_FLAGS, 32'hff);
			ex(6'h21, s[2:0], 5'h00, 8'h00);
			rd(fbx_pkg::ADDR_FLAGS);
			chk("flag force zero", 32'hff ^ (32'h1 << s), rdat);
		end
		for (int o = 6'h24; o <= 6'h27; o++) begin
			wr(fbx_pkg::ADDR_FLAGS, o[0] ? 32'hff : 32'h00);
			ex(o[5:0], 3'h0, 5'h00, 8'h00);
			rd(fbx_pkg::ADDR_FLAGS);
			chk("fixed flag force", (o[0] ? 32'hff : 32'h0) ^ (o[1] ? 32'h20 : 32'h08), rdat);
		end
		$display("test flag done");
	endtask

	task automatic t_bit;
		for (int b = 0; b < 8; b++) begin
			wr(fbx_pkg::ADDR_WORK, {24'h0, BSRC});
			wr(fbx_pkg::ADDR_FLAGS, 32'hbf);
			ex(6'h22, b[2:0], 5'h00, 8'h00);
			rd(fbx_pkg::ADDR_FLAGS);
			chk("copy to t", {24'h0, 1'b1, BSRC[b], 6'h3f}, rdat);
			wr(fbx_pkg::ADDR_FLAGS, b[0] ? 32'h40 : 32'h00);
			wr(fbx_pkg::ADDR_WORK, b[0] ? 32'h00 : 32'hff);
			ex(6'h23, b[2:0], 5'h00, 8'h00);
			rd(fbx_pkg::ADDR_WORK);
			chk("copy from t", b[0] ? 32'h1 << b : 32'hff ^ (32'h1 << b), rdat);
			rd(fbx_pkg::ADDR_FLAGS);
			chk("copy from t flags", b[0] ? 32'h40 : 32'h00, rdat);
		end
		$display("test bit done");
	endtask

	task automatic t_io;
		wr(8'h94, 32'h5a);
		wr(fbx_pkg::ADDR_FLAGS, 32'h3c);
		ex(6'h10, 3'h0, 5'h05, 8'h00);
		rd(8'h94);
		chk("io force one", 32'h5b, rdat);
		ex(6'h11, 3'h6, 5'h05, 8'h00);
		rd(8'h94);
		chk("io force zero", 32'h1b, rdat);
		rd(fbx_pkg::ADDR_STAT);
		chk("io cycles", 32'h20, rdat & 32'h30);
		rd(fbx_pkg::ADDR_FLAGS);
		chk("io flags kept", 32'h3c, rdat);
		ex(6'h10, 3'h7, 5'(IO_N), 8'h00);
		rd(fbx_pkg::ADDR_IO_BASE + 8'(IO_N * 4));
		chk("io range err", 32'h1, {31'h0, rerr});
		rd(fbx_pkg::ADDR_RETIRED);
		chk("retired count", ninsn, rdat);
		$display("test io done");
	endtask

	// Reset for two cycles, then run every scenario
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		error_cnt = 0;
		checked = 0;
		ninsn = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_branch();
		t_shift();
		t_flag();
		t_bit();
		t_io();
		end_of_test();
	end
endmodule

bind fbx_exec fbx_chk #(.IO_DEPTH(IO_DEPTH)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .exec_busy(exec_busy), .prog_counter(prog_counter));
